// ==== hdl/bmsc_top.sv ====
// bmsc_top: mode and set point control for three buck regulators
// assumes all pins are synchronous to sys_clk_in and oscillators arrive as enable pulses
//
// Overview of operation
// - untrimmed 32 kHz only below undervoltage, all asleep, or all in PFM
// - derived 32 kHz used for start-up above undervoltage and edge-mode button debounce
// - button debounce counts derived ticks in edge mode; input-voltage and enable interrupts count untrimmed ticks
// - start-up slot timing counts trimmed 32 kHz ticks times slot and sequence speed
// - switching clock ticks come from dividing the trimmed 16 MHz oscillator
// - at start-up fused code is copied into normal, standby and sleep set points
// - host may write set points afterwards; applied in on, standby, sleep
// - switching mode follows host writes, standby and sleep changes
// - a regulator whose mode is off is disabled and discharged
// - every regulator powers up with the pulse-skip default mode field
// - soft-start walks PFM, pulse-skip, PWM; selected mode 3.0 ms after regulation
// - four-bit mode field decodes to normal and standby switching modes
// - standby uses standby set point and mode; leaving standby restores normal
// - turn-off sends keep-on regulators to sleep unless still waiting for their slot, and turns the others off
// - sleeping regulator outputs its sleep set point in PFM mode
// - turn-on wakes a sleeping regulator into normal set point and mode
// - turn-on restarts an off regulator with a non-zero slot in its slot, with fused set points and default mode field
// - sleep set point widths are five, three and four bits
// - edge mode: falling edge turns on; low for 4.0 s turns off
// - ramp steps one set point code every 2.0 or 4.0 us
`timescale 1ns/1ps
module bmsc_top import bmsc_pkg::*; #(
    parameter int HOLD_TICKS = HOLD_TICK,
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic osc16_tick_in,
    input wire logic untrim_tick_in,
    input wire logic vin_below_undervoltage_threshold_in,
    input wire logic enable_pin_in,
    input wire logic en_edge_cfg_in,
    input wire logic standby_in,
    input wire logic ramp_speed_select_in,
    input wire logic seq_slow_in,
    input wire logic [NREG-1:0][4:0] fused_voltage_code_in,
    input wire logic [NREG-1:0][3:0] slot_in,
    input wire bmsc_wr_t host_wr_in,
    output bmsc_stat_t [NREG-1:0] reg_stat_out,
    output logic switch_tick_out,
    output logic use_untrimmed_out,
    output logic powered_on_out,
    output logic low_input_voltage_interrupt_out,
    output logic enable_pin_interrupt_out
);
    // ****************************************
    // clock sources
    // ****************************************
    typedef enum logic [1:0] {PS_COLD = 2'b00, PS_OFF = 2'b01, PS_ON = 2'b10} bmsc_ps_t;
    bmsc_ps_t pstate, next_pstate;
    bmsc_stat_t [NREG-1:0] stat;
    logic trim32_tick;
    logic button_tick;
    logic [NREG-1:0] sleep_vec, pfm_vec, start_vec;
    always_comb begin
        for (int k = 0; k < NREG; k++) begin
            sleep_vec[k] = stat[k].asleep;
            pfm_vec[k] = stat[k].mode == SM_PFM;
            start_vec[k] = stat[k].starting;
        end
    end
    wire all_sleep = &sleep_vec;
    wire all_pfm = &pfm_vec;
    wire any_start = (|start_vec) || (pstate == PS_COLD);

    bmsc_clk_select u_clk (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .osc16_tick_in(osc16_tick_in),
        .untrim_tick_in(untrim_tick_in),
        .vin_low_in(vin_below_undervoltage_threshold_in),
        .all_sleep_in(all_sleep),
        .all_pfm_in(all_pfm),
        .starting_in(any_start),
        .edge_cfg_in(en_edge_cfg_in),
        .trim32_tick_out(trim32_tick),
        .button_tick_out(button_tick),
        .use_untrim_out(use_untrimmed_out),
        .switch_tick_out(switch_tick_out)
    );

    // ****************************************
    // debounce: input voltage, enable interrupt, enable button
    // ****************************************
    localparam int NDEB = 3;
    wire [NDEB-1:0] deb_raw = {enable_pin_in, enable_pin_in, vin_below_undervoltage_threshold_in};
    // the interrupt filters stay on the untrimmed source so they run in every state
    wire [NDEB-1:0] deb_tick = {button_tick, untrim_tick_in, untrim_tick_in};
    logic [NDEB-1:0] deb_q;
    logic [NDEB-1:0] deb_prev;
    genvar d;
    generate
        for (d = 0; d < NDEB; d++) begin : g_deb
            logic [2:0] cnt;
            wire differs = deb_raw[d] != deb_q[d];
            always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    cnt <= 3'h0;
                    // input voltage starts as low so cold load waits for a debounced good supply
                    deb_q[d] <= (d == 0);
                    deb_prev[d] <= (d == 0);
                end else begin
                    deb_prev[d] <= deb_q[d];
                    if (!differs) cnt <= 3'h0;
                    else if (deb_tick[d]) cnt <= cnt + 3'h1;
                    if (differs && deb_tick[d] && cnt == DEB_TICKS - 3'h1) deb_q[d] <= deb_raw[d];
                end
            end
        end
    endgenerate
    wire vin_ok = !deb_q[0];
    wire btn = deb_q[2];
    wire btn_fall = deb_prev[2] && !btn;

    // ****************************************
    // power state and enable pin
    // ****************************************
    logic [16:0] hold_cnt;
    wire hold_done = hold_cnt >= 17'(HOLD_TICKS - 1);
    wire edge_on = en_edge_cfg_in && btn_fall;
    wire edge_off = en_edge_cfg_in && !btn && hold_done && trim32_tick;
    wire lvl_on = !en_edge_cfg_in && btn;
    wire lvl_off = !en_edge_cfg_in && !btn;
    logic load;
    logic turn_on;
    logic turn_off;
    always_comb begin
        next_pstate = pstate;
        load = 1'b0;
        turn_on = 1'b0;
        turn_off = 1'b0;
        case (pstate)
            PS_COLD: begin
                if (vin_ok) begin
                    load = 1'b1;
                    next_pstate = PS_OFF;
                end
            end
            PS_OFF: begin
                if (edge_on || lvl_on) begin
                    turn_on = 1'b1;
                    next_pstate = PS_ON;
                end
            end
            PS_ON: begin
                if (edge_off || lvl_off) begin
                    turn_off = 1'b1;
                    next_pstate = PS_OFF;
                end
            end
            default: next_pstate = PS_COLD;
        endcase
    end
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pstate <= PS_COLD;
            hold_cnt <= 17'h00000;
        end else begin
            pstate <= next_pstate;
            // hold timing is on the trimmed tick so 4 s is accurate
            if (btn || pstate != PS_ON) hold_cnt <= 17'h00000;
            else if (trim32_tick && !hold_done) hold_cnt <= hold_cnt + 17'h00001;
        end
    end

    // ****************************************
    // ramp step timer
    // ****************************************
    logic [6:0] ramp_cnt;
    logic ramp_tick;
    wire [6:0] ramp_len = ramp_speed_select_in ? RAMP_SLOW_CYC : RAMP_FAST_CYC;
    wire ramp_wrap = ramp_cnt >= ramp_len - 7'h01;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ramp_cnt <= 7'h00;
            ramp_tick <= 1'b0;
        end else begin
            ramp_cnt <= ramp_wrap ? 7'h00 : ramp_cnt + 7'h01;
            ramp_tick <= ramp_wrap;
        end
    end

    // ****************************************
    // regulators
    // ****************************************
    wire stby = standby_in && (pstate == PS_ON);
    genvar r;
    generate
        for (r = 0; r < NREG; r++) begin : g_reg
            bmsc_buck_ctrl #(
                .SW(SLEEP_W[r]),
                .SETTLE(SETTLE_CYCLES)
            ) u_buck (
                .sys_clk_in(sys_clk_in),
                .rst_b_in(rst_b_in),
                .load_in(load),
                .turn_on_in(turn_on),
                .turn_off_in(turn_off),
                .standby_in(stby),
                .ramp_tick_in(ramp_tick),
                .trim32_tick_in(trim32_tick),
                .seq_slow_in(seq_slow_in),
                .fused_in(fused_voltage_code_in[r]),
                .slot_in(slot_in[r]),
                .wr_sel_in(host_wr_in.index == 2'(r)),
                .wr_in(host_wr_in),
                .stat_out(stat[r])
            );
        end
    endgenerate

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_stat_out <= '{default: '{discharge: 1'b1, mode: SM_OFF, default: '0}};
            powered_on_out <= 1'b0;
            low_input_voltage_interrupt_out <= 1'b0;
            enable_pin_interrupt_out <= 1'b0;
        end else begin
            reg_stat_out <= stat;
            powered_on_out <= pstate == PS_ON;
            low_input_voltage_interrupt_out <= deb_q[0] && !deb_prev[0];
            enable_pin_interrupt_out <= deb_q[1] != deb_prev[1];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence ramp_quiet_s;
        (!ramp_tick)[*8];
    endsequence
    sequence held_low_s;
        (!btn && pstate == PS_ON)[*2];
    endsequence
    untrim_select_a: assert property (vin_below_undervoltage_threshold_in |=> use_untrimmed_out)
        else $error("untrimmed clock not selected");
    derived_start_a: assert property (any_start && !vin_below_undervoltage_threshold_in |=> !use_untrimmed_out)
        else $error("start-up not on derived clock");
    edge_button_a: assert property (en_edge_cfg_in && trim32_tick |-> button_tick)
        else $error("button debounce not on derived tick");
    ramp_space_a: assert property (ramp_tick |=> ramp_quiet_s) else $error("ramp steps too close");
    ramp_gap_a: assert property (ramp_tick |-> ##[1:100] ramp_tick) else $error("ramp step missing");
    edge_on_a: assert property (pstate == PS_OFF && edge_on |=> pstate == PS_ON)
        else $error("falling edge did not turn on");
    hold_off_a: assert property (held_low_s ##0 (en_edge_cfg_in && edge_off) |=> pstate == PS_OFF)
        else $error("long press did not turn off");
    generate
        for (r = 0; r < NREG; r++) begin : g_chk
            off_discharge_a: assert property (stat[r].mode == SM_OFF |-> stat[r].discharge && !stat[r].enable)
                else $error("off regulator not discharged");
            sleep_pfm_a: assert property (stat[r].asleep |-> stat[r].mode == SM_PFM)
                else $error("sleep not in pfm");
            keep_sleep_a: assert property (turn_off && stat[r].keep_on && stat[r].enable |-> ##1 stat[r].asleep)
                else $error("keep-on regulator did not sleep");
            drop_off_a: assert property (turn_off && !stat[r].keep_on |-> ##1 !stat[r].enable)
                else $error("regulator not turned off");
            wake_a: assert property (turn_on && stat[r].asleep |-> ##1 (!stat[r].asleep && !stat[r].starting))
                else $error("sleeping regulator did not wake");
        end
    endgenerate
endmodule // bmsc_top

// ==== include/bmsc_pkg.sv ====
// bmsc_pkg: constants, types and mode decode for the buck mode and set point control
// assumes a 25 MHz system clock; oscillators arrive as one-cycle enable pulses
package bmsc_pkg;
    localparam int NREG = 3;
    localparam int SYS_NS = 40;
    // ****************************************
    // timing
    // ****************************************
    localparam int FAST_HZ = 16000000;
    localparam int SLOW_HZ = 32000;
    localparam logic [9:0] DIV32 = 10'(FAST_HZ / SLOW_HZ);
    localparam logic [3:0] SW_DIV = 4'h8;
    localparam int RAMP_FAST_NS = 2000;
    localparam int RAMP_SLOW_NS = 4000;
    localparam logic [6:0] RAMP_FAST_CYC = 7'(RAMP_FAST_NS / SYS_NS);
    localparam logic [6:0] RAMP_SLOW_CYC = 7'(RAMP_SLOW_NS / SYS_NS);
    localparam int SEQ_FAST_US = 500;
    localparam int SEQ_SLOW_US = 2000;
    localparam logic [9:0] SEQ_FAST_TICKS = 10'(SEQ_FAST_US * (SLOW_HZ / 1000) / 1000);
    localparam logic [9:0] SEQ_SLOW_TICKS = 10'(SEQ_SLOW_US * (SLOW_HZ / 1000) / 1000);
    localparam int SETTLE_US = 3000;
    localparam int SETTLE_CYC = SETTLE_US * 1000 / SYS_NS;
    localparam int HOLD_MS = 4000;
    localparam int HOLD_TICK = HOLD_MS * (SLOW_HZ / 1000);
    localparam logic [2:0] DEB_TICKS = 3'h4;
    localparam int SLEEP_W [NREG] = '{5, 3, 4};
    // ****************************************
    // encodings
    // ****************************************
    localparam logic [3:0] MODE_DEFAULT = 4'h8;
    typedef enum logic [1:0] {SM_OFF = 2'b00, SM_PWM = 2'b01, SM_PFM = 2'b10, SM_APS = 2'b11} bmsc_sw_t;
    typedef enum logic [2:0] {F_NORMAL = 3'b000, F_STANDBY = 3'b001, F_SLEEP = 3'b010,
        F_MODE = 3'b011, F_KEEP = 3'b100} bmsc_field_t;
    typedef struct packed {
        logic strobe;
        logic [1:0] index;
        bmsc_field_t field;
        logic [4:0] data;
    } bmsc_wr_t;
    typedef struct packed {
        logic enable;
        logic discharge;
        logic asleep;
        logic starting;
        logic keep_on;
        bmsc_sw_t mode;
        logic [4:0] setpoint;
    } bmsc_stat_t;
    typedef struct packed {
        bmsc_sw_t normal;
        bmsc_sw_t standby;
    } bmsc_pair_t;
    // reserved codes fall back to the default pairing
    function automatic bmsc_pair_t bmsc_decode(input logic [3:0] f);
        case (f)
            4'h0: bmsc_decode = '{SM_OFF, SM_OFF};
            4'h1: bmsc_decode = '{SM_PWM, SM_OFF};
            4'h3: bmsc_decode = '{SM_PFM, SM_OFF};
            4'h4: bmsc_decode = '{SM_APS, SM_OFF};
            4'h5: bmsc_decode = '{SM_PWM, SM_PWM};
            4'h6: bmsc_decode = '{SM_PWM, SM_APS};
            4'hC: bmsc_decode = '{SM_APS, SM_PFM};
            4'hD: bmsc_decode = '{SM_PWM, SM_PFM};
            default: bmsc_decode = '{SM_APS, SM_APS};
        endcase
    endfunction
endpackage

// ==== hdl/bmsc_clk_select.sv ====
// bmsc_clk_select: derived 32 kHz tick, switching tick and timing source choice
// assumes osc pulses are single-cycle enables in the system clock domain
`timescale 1ns/1ps
module bmsc_clk_select import bmsc_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic osc16_tick_in,
    input wire logic untrim_tick_in,
    input wire logic vin_low_in,
    input wire logic all_sleep_in,
    input wire logic all_pfm_in,
    input wire logic starting_in,
    input wire logic edge_cfg_in,
    output logic trim32_tick_out,
    output logic button_tick_out,
    output logic use_untrim_out,
    output logic switch_tick_out
);
    logic [9:0] div_cnt;
    logic [3:0] sw_cnt;
    wire div_wrap = osc16_tick_in && (div_cnt == DIV32 - 10'h001);
    wire sw_wrap = osc16_tick_in && (sw_cnt == SW_DIV - 4'h1);
    // undervoltage forces the untrimmed source; accurate start-up timing otherwise wins
    wire next_untrim = vin_low_in || ((all_sleep_in || all_pfm_in) && !starting_in && !edge_cfg_in);
    wire next_button = edge_cfg_in ? div_wrap : (next_untrim ? untrim_tick_in : div_wrap);
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_cnt <= 10'h000;
            sw_cnt <= 4'h0;
            trim32_tick_out <= 1'b0;
            button_tick_out <= 1'b0;
            use_untrim_out <= 1'b1;
            switch_tick_out <= 1'b0;
        end else begin
            if (osc16_tick_in) div_cnt <= div_wrap ? 10'h000 : div_cnt + 10'h001;
            if (osc16_tick_in) sw_cnt <= sw_wrap ? 4'h0 : sw_cnt + 4'h1;
            trim32_tick_out <= div_wrap;
            switch_tick_out <= sw_wrap;
            use_untrim_out <= next_untrim;
            button_tick_out <= next_button;
        end
    end
endmodule // bmsc_clk_select

// ==== hdl/bmsc_buck_ctrl.sv ====
// bmsc_buck_ctrl: set points, mode field and on/sleep/off sequencing of one buck regulator
// assumes event pulses are one cycle wide and ticks come from the top
`timescale 1ns/1ps
module bmsc_buck_ctrl import bmsc_pkg::*; #(
    parameter int SW = 5,
    parameter int SETTLE = SETTLE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic load_in,
    input wire logic turn_on_in,
    input wire logic turn_off_in,
    input wire logic standby_in,
    input wire logic ramp_tick_in,
    input wire logic trim32_tick_in,
    input wire logic seq_slow_in,
    input wire logic [4:0] fused_in,
    input wire logic [3:0] slot_in,
    input wire logic wr_sel_in,
    input wire bmsc_wr_t wr_in,
    output bmsc_stat_t stat_out
);
    typedef enum logic [2:0] {RS_OFF = 3'b000, RS_WAIT = 3'b001, RS_RAMP = 3'b010,
        RS_SETTLE = 3'b011, RS_ON = 3'b100, RS_SLEEP = 3'b101} bmsc_rs_t;
    bmsc_rs_t state, next_state;
    logic [4:0] normal_setpoint, standby_setpoint, cur;
    logic [SW-1:0] sleep_setpoint;
    logic [3:0] regulator_mode_select;
    logic sleep_keep_on_enable;
    logic [9:0] wait_cnt;
    logic [16:0] settle_cnt;
    wire restart = turn_on_in && (state == RS_OFF);
    wire reload = load_in || restart;
    wire wr = wr_in.strobe && wr_sel_in && !reload;
    wire bmsc_pair_t pair = bmsc_decode(regulator_mode_select);
    wire [9:0] wait_end = 10'(slot_in) * (seq_slow_in ? SEQ_SLOW_TICKS : SEQ_FAST_TICKS);
    wire [4:0] target = (state == RS_SLEEP) ? 5'(sleep_setpoint) :
        (state == RS_ON && standby_in) ? standby_setpoint : normal_setpoint;
    wire live = (state == RS_RAMP) || (state == RS_SETTLE) || (state == RS_ON) || (state == RS_SLEEP);
    wire step = live && ramp_tick_in && (cur != target);
    wire settle_done = settle_cnt == 17'(SETTLE - 1);
    bmsc_sw_t mode;
    always_comb begin
        case (state)
            RS_RAMP: mode = (cur == 5'h00) ? SM_PFM : SM_APS;
            RS_SETTLE: mode = SM_PWM;
            RS_ON: mode = standby_in ? pair.standby : pair.normal;
            RS_SLEEP: mode = SM_PFM;
            default: mode = SM_OFF;
        endcase
    end
    always_comb begin
        next_state = state;
        case (state)
            RS_OFF: if (restart && slot_in != 4'h0) next_state = RS_WAIT;
            RS_WAIT: if (trim32_tick_in && wait_cnt >= wait_end) next_state = RS_RAMP;
            RS_RAMP: if (cur == target) next_state = RS_SETTLE;
            RS_SETTLE: if (settle_done) next_state = RS_ON;
            RS_SLEEP: if (turn_on_in) next_state = RS_ON;
            default: next_state = state;
        endcase
        if (turn_off_in && state != RS_OFF) begin
            next_state = (sleep_keep_on_enable && state != RS_WAIT) ? RS_SLEEP : RS_OFF;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= RS_OFF;
            cur <= 5'h00;
            wait_cnt <= 10'h000;
            settle_cnt <= 17'h00000;
        end else begin
            state <= next_state;
            if (!live) cur <= 5'h00;
            else if (step) cur <= (cur < target) ? cur + 5'h01 : cur - 5'h01;
            if (state != RS_WAIT) wait_cnt <= 10'h000;
            else if (trim32_tick_in) wait_cnt <= wait_cnt + 10'h001;
            settle_cnt <= (state == RS_SETTLE) ? settle_cnt + 17'h00001 : 17'h00000;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            normal_setpoint <= 5'h00;
            standby_setpoint <= 5'h00;
            sleep_setpoint <= '0;
            regulator_mode_select <= MODE_DEFAULT;
            sleep_keep_on_enable <= 1'b0;
        end else if (reload) begin
            normal_setpoint <= fused_in;
            standby_setpoint <= fused_in;
            sleep_setpoint <= fused_in[SW-1:0];
            regulator_mode_select <= MODE_DEFAULT;
        end else if (wr) begin
            if (wr_in.field == F_NORMAL) normal_setpoint <= wr_in.data;
            if (wr_in.field == F_STANDBY) standby_setpoint <= wr_in.data;
            if (wr_in.field == F_SLEEP) sleep_setpoint <= wr_in.data[SW-1:0];
            if (wr_in.field == F_MODE) regulator_mode_select <= wr_in.data[3:0];
            if (wr_in.field == F_KEEP) sleep_keep_on_enable <= wr_in.data[0];
        end
    end
    assign stat_out = '{enable: mode != SM_OFF, discharge: mode == SM_OFF, asleep: state == RS_SLEEP,
        starting: state == RS_WAIT || state == RS_RAMP, keep_on: sleep_keep_on_enable, mode: mode, setpoint: cur};
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    fused_load_a: assert property (load_in |=> normal_setpoint == $past(fused_in)
        && standby_setpoint == $past(fused_in)) else $error("fused code not copied");
    restart_default_a: assert property (restart |=> regulator_mode_select == MODE_DEFAULT)
        else $error("restart lost default mode");
    settle_pwm_a: assert property (state == RS_SETTLE |-> mode == SM_PWM) else $error("settle not pwm");
    host_write_a: assert property (wr && wr_in.field == F_NORMAL |=> normal_setpoint == $past(wr_in.data))
        else $error("host write lost");
endmodule // bmsc_buck_ctrl

// ==== sim/bmsc_osc_model.sv ====
// bmsc_osc_model: oscillator side, 16 MHz and 32 kHz sources as enable pulses
// assumes a 25 MHz sys_clk_in; pulses change just after the rising edge
`timescale 1ns/1ps
module bmsc_osc_model (
    input wire logic sys_clk_in,
    output logic osc16_tick_out,
    output logic untrim_tick_out
);
    int acc = 0;
    int cnt = 0;
    initial osc16_tick_out = 1'b0;
    initial untrim_tick_out = 1'b0;
    // untrimmed source is left a little fast on purpose: it is not accurate
    always @(posedge sys_clk_in) begin
        acc <= (acc + 16) % 25;
        osc16_tick_out <= (acc + 16 >= 25);
        cnt <= (cnt == 760) ? 0 : cnt + 1;
        untrim_tick_out <= (cnt == 760);
    end
endmodule // bmsc_osc_model

// ==== sim/tb_top.sv ====
// tb_top: start-up, mode, standby and sleep scenarios for three regulators
// assumes the oscillator model supplies the ticks; level enable only
`timescale 1ns/1ps
module tb_top import bmsc_pkg::*;;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic vin = 1'b1;
    logic en = 1'b0;
    logic stby = 1'b0;
    logic osc16;
    logic untrim;
    bmsc_wr_t hw = '0;
    bmsc_stat_t [NREG-1:0] st;
    logic uu;
    logic pon;
    int error_cnt = 0;
    int total_checks = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    bmsc_osc_model i_osc (.sys_clk_in(sys_clk_in), .osc16_tick_out(osc16), .untrim_tick_out(untrim));
    // short hold and settle keep the run within budget
    bmsc_top #(.HOLD_TICKS(4), .SETTLE_CYCLES(8)) i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .osc16_tick_in(osc16), .untrim_tick_in(untrim), .vin_below_undervoltage_threshold_in(vin),
        .enable_pin_in(en), .en_edge_cfg_in(1'b0), .standby_in(stby), .ramp_speed_select_in(1'b0),
        .seq_slow_in(1'b0), .fused_voltage_code_in({5'h00, 5'h02, 5'h03}), .slot_in({4'h0, 4'h1, 4'h1}),
        .host_wr_in(hw), .reg_stat_out(st), .switch_tick_out(), .use_untrimmed_out(uu),
        .powered_on_out(pon), .low_input_voltage_interrupt_out(), .enable_pin_interrupt_out());
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test();
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input logic [1:0] i, input bmsc_field_t f, input logic [4:0] d);
        @(posedge sys_clk_in) hw <= '{1'b1, i, f, d};
        @(posedge sys_clk_in) hw.strobe <= 1'b0;
    endtask
    // waits for the ramp to reach sp, then past the settle time
    task wait_sp(input int i, input logic [4:0] sp);
        for (int n = 0; n < 20000 && st[i].setpoint !== sp; n++) @(posedge sys_clk_in);
        repeat (40) @(posedge sys_clk_in);
        #1;
    endtask
    task t_start();
        @(posedge sys_clk_in) vin <= 1'b0;
        en <= 1'b1;
        wait_sp(0, 5'h03);
        chk(st[0].setpoint, 8'h03);
        chk(st[0].mode, SM_APS);
        wait_sp(1, 5'h02);
        chk(st[1].enable, 8'h01);
        chk(st[2].enable, 8'h00);
        chk(pon, 8'h01);
    endtask
    task t_mode();
        wr(0, F_MODE, 5'h05);
        wr(0, F_NORMAL, 5'h05);
        wait_sp(0, 5'h05);
        chk(st[0].mode, SM_PWM);
        wr(0, F_STANDBY, 5'h02);
        @(posedge sys_clk_in) stby <= 1'b1;
        wait_sp(0, 5'h02);
        chk(st[0].mode, SM_PWM);
        wr(0, F_MODE, 5'h01);
        wait_sp(0, 5'h02);
        chk({st[0].enable, st[0].discharge}, 8'h01);
        @(posedge sys_clk_in) stby <= 1'b0;
        wait_sp(0, 5'h05);
        chk(st[0].mode, SM_PWM);
    endtask
    task t_sleep();
        wr(0, F_KEEP, 5'h01);
        wr(0, F_SLEEP, 5'h01);
        @(posedge sys_clk_in) en <= 1'b0;
        wait_sp(0, 5'h01);
        chk({st[0].asleep, st[0].mode}, {1'b1, SM_PFM});
        chk({st[1].enable, st[1].discharge}, 8'h01);
        chk(pon, 8'h00);
        @(posedge sys_clk_in) en <= 1'b1;
        wait_sp(0, 5'h05);
        chk({st[0].asleep, st[0].mode}, {1'b0, SM_PWM});
        wait_sp(1, 5'h02);
        chk(st[1].mode, SM_APS);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk({st[0].discharge, st[0].mode, uu}, {1'b1, SM_OFF, 1'b1});
        @(posedge sys_clk_in) rst_b_in <= 1'b1;
        t_start();
        t_mode();
        t_sleep();
        end_of_test();
    end
    initial begin
        #3000000;
        error_cnt++;
        end_of_test();
    end
endmodule // tb_top
